// ==== logic/misc_host_config_register.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "misc_cfg_defines.svh"
module misc_host_config_register
(
	// Clock and reset
	input  wire logic                   ref_clk_in,
	input  wire logic                   reset_in,
	// Configuration access
	input  wire misc_cfg_pkg::cfg_req_s cfg_req_in,
	output logic                        cfg_ack_out,
	output logic [31:0]                 cfg_rdata_out,
	// EEPROM initial load
	input  wire misc_cfg_pkg::ee_word_s ee_word_in,
	// Wake generation
	input  wire logic                   irq_pending_in,
	input  wire logic                   master_interrupt_gate_in,
	output logic                        wake_event_out,
	output logic                        pm_cap_wake_cold_out,
	output logic                        link_vendor_bit26_out,
	// Bus master read
	input  wire logic                   rd_req_in,
	input  wire logic [7:0]             rd_phases_in,
	output logic                        rd_cmd_valid_out,
	output logic [3:0]                  rd_cmd_out,
	// Link register access
	input  wire misc_cfg_pkg::link_req_s link_req_in,
	output logic                        link_done_out,
	output logic                        link_abort_out,
	output logic [31:0]                 link_rdata_out,
	// General pins and EEPROM bus
	input  wire logic                   general_pin_three_in,
	input  wire logic                   general_pin_two_in,
	input  wire logic                   gpio_three_drive_in,
	input  wire logic                   gpio_three_oe_in,
	input  wire logic                   gpio_two_drive_in,
	input  wire logic                   gpio_two_oe_in,
	output logic                        general_pin_three_out,
	output logic                        general_pin_three_oe_out,
	output logic                        general_pin_two_out,
	output logic                        general_pin_two_oe_out,
	output logic                        gpio_three_seen_out,
	output logic                        gpio_two_seen_out,
	input  wire logic                   ee_clk_drive_in,
	input  wire logic                   ee_clk_oe_in,
	input  wire logic                   ee_data_drive_in,
	input  wire logic                   ee_data_oe_in,
	input  wire logic                   ee_clk_pin_in,
	input  wire logic                   ee_data_pin_in,
	output logic                        ee_clk_out,
	output logic                        ee_clk_oe_out,
	output logic                        ee_data_out,
	output logic                        ee_data_oe_out,
	// Clock control
	input  wire logic                   sclk_gate_en_in,
	input  wire logic                   hclk_gate_en_in,
	input  wire logic                   hclk_needed_in,
	output logic                        sclk_run_out,
	output logic                        hclk_run_out,
	output logic                        clkrun_keep_out
);
	import misc_cfg_pkg::*;

	// ==========================================
	// State
	state_s cur_reg;
	state_s cur_next;
	logic   hit;
	logic   long_rd;

	// Register image as software sees it
	function automatic logic [31:0] cfg_word(input fields_s f);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`BIT_WAKE_COLD] = f.wake_cold;
		w[`BIT_WAKE_IGN] = f.wake_ign;
		w[`BIT_RDSEL_HI:`BIT_RDSEL_LO] = f.rd_sel;
		w[`BIT_SUP_ABORT] = f.sup_abort;
		w[`BIT_PIN_ROUTE] = f.pin_route;
		w[`BIT_SCLK_BYP] = f.sclk_byp;
		w[`BIT_HCLK_BYP] = f.hclk_byp;
		w[`BIT_KEEP_HCLK] = f.keep_hclk;
		return w;
	endfunction

	// Bus read command from length and field
	function automatic logic [3:0] read_cmd(
		input logic [7:0] phases,
		input logic [1:0] sel
	);
		logic [3:0] c;
		c = `CMD_MEM_READ_LN;
		if (phases <= `SHORT_READ_MAX)
			c = `CMD_MEM_READ;
		else if (sel == `RDSEL_PLAIN)
			c = `CMD_MEM_READ;
		else if (sel == `RDSEL_MULTIPLE)
			c = `CMD_MEM_READ_MUL;
		return c;
	endfunction

	// ==========================================
	// Decode
	assign hit = cfg_req_in.sel && (cfg_req_in.addr[7:2] == 6'(`MCFG_OFFSET >> 2));
	assign long_rd = rd_phases_in > `SHORT_READ_MAX;

	// Next state
	always_comb
	begin
		cur_next = cur_reg;
		cur_next.ack = 1'h0;
		cur_next.rd_vld = 1'h0;
		cur_next.lk_done = 1'h0;
		cur_next.lk_abort = 1'h0;
		if (hit && !cfg_req_in.wr)
		begin
			cur_next.rdata = cfg_word(cur_reg.f);
			cur_next.ack = 1'h1;
		end
		if (hit && cfg_req_in.wr)
		begin
			cur_next.ack = 1'h1;
			// Only writable bits taken
			if (cfg_req_in.be[0])
			begin
				cur_next.f.sup_abort = cfg_req_in.wdata[`BIT_SUP_ABORT];
				cur_next.f.pin_route = cfg_req_in.wdata[`BIT_PIN_ROUTE];
				cur_next.f.sclk_byp = cfg_req_in.wdata[`BIT_SCLK_BYP];
				cur_next.f.hclk_byp = cfg_req_in.wdata[`BIT_HCLK_BYP];
				cur_next.f.keep_hclk = cfg_req_in.wdata[`BIT_KEEP_HCLK];
			end
			if (cfg_req_in.be[1])
			begin
				cur_next.f.wake_cold = cfg_req_in.wdata[`BIT_WAKE_COLD];
				cur_next.f.wake_ign = cfg_req_in.wdata[`BIT_WAKE_IGN];
				cur_next.f.rd_sel = cfg_req_in.wdata[`BIT_RDSEL_HI:`BIT_RDSEL_LO];
			end
		end
		// EEPROM load wins over a same-cycle write
		if (ee_word_in.valid && ee_word_in.addr == `EE_RDSEL_WORD)
			cur_next.f.rd_sel = ee_word_in.data[1:0];
		// Wake gated by master enable unless ignored
		cur_next.wake = irq_pending_in &&
			(master_interrupt_gate_in || cur_reg.f.wake_ign);
		if (rd_req_in)
		begin
			cur_next.rd_vld = 1'h1;
			cur_next.rd_cmd = read_cmd(rd_phases_in, cur_reg.f.rd_sel);
		end
		if (link_req_in.valid)
		begin
			cur_next.lk_done = 1'h1;
			cur_next.lk_rdata = link_req_in.rdata;
			if (!link_req_in.sclk_active)
			begin
				// Idle serial domain: abort or fill
				cur_next.lk_abort = !cur_reg.f.sup_abort;
				cur_next.lk_done = cur_reg.f.sup_abort;
				cur_next.lk_rdata = cur_reg.f.sup_abort ?
					`LINK_FILL_DATA : 32'h0000_0000;
			end
		end
	end

	// Register update
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			cur_reg <= state_s'(0);
			cur_reg.f <= fields_s'(`MCFG_RESET);
		end
		else
			cur_reg <= cur_next;
	end

	// ==========================================
	// Outputs
	assign cfg_ack_out = cur_reg.ack;
	assign cfg_rdata_out = cur_reg.rdata;
	assign wake_event_out = cur_reg.wake;
	assign pm_cap_wake_cold_out = cur_reg.f.wake_cold;
	assign link_vendor_bit26_out = cur_reg.f.wake_ign;
	assign rd_cmd_valid_out = cur_reg.rd_vld;
	assign rd_cmd_out = cur_reg.rd_cmd;
	assign link_done_out = cur_reg.lk_done;
	assign link_abort_out = cur_reg.lk_abort;
	assign link_rdata_out = cur_reg.lk_rdata;

	// Pin routing onto the EEPROM bus
	assign general_pin_three_out = gpio_three_drive_in;
	assign general_pin_two_out = gpio_two_drive_in;
	assign general_pin_three_oe_out = gpio_three_oe_in && !cur_reg.f.pin_route;
	assign general_pin_two_oe_out = gpio_two_oe_in && !cur_reg.f.pin_route;
	assign ee_clk_out = cur_reg.f.pin_route ? gpio_three_drive_in : ee_clk_drive_in;
	assign ee_clk_oe_out = cur_reg.f.pin_route ? gpio_three_oe_in : ee_clk_oe_in;
	assign ee_data_out = cur_reg.f.pin_route ? gpio_two_drive_in : ee_data_drive_in;
	assign ee_data_oe_out = cur_reg.f.pin_route ? gpio_two_oe_in : ee_data_oe_in;
	assign gpio_three_seen_out = cur_reg.f.pin_route ? ee_clk_pin_in : general_pin_three_in;
	assign gpio_two_seen_out = cur_reg.f.pin_route ? ee_data_pin_in : general_pin_two_in;

	// Clock gate bypass and keep-running request
	assign sclk_run_out = sclk_gate_en_in || cur_reg.f.sclk_byp;
	assign hclk_run_out = hclk_gate_en_in || cur_reg.f.hclk_byp;
	assign clkrun_keep_out = hclk_needed_in || cur_reg.f.keep_hclk;

	// ==========================================
	// Assertions
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (reset_in);

	// Steps of a read-modify-write
	sequence s_write_all;
		hit && cfg_req_in.wr && cfg_req_in.be == 4'hF &&
			cfg_req_in.wdata == 32'hFFFF_FFFF && !ee_word_in.valid;
	endsequence
	sequence s_read;
		hit && !cfg_req_in.wr;
	endsequence
	sequence s_wr_hi;
		hit && cfg_req_in.wr && cfg_req_in.be[1];
	endsequence

	AST_UPPER_ZERO: assert property (cfg_ack_out |-> cfg_rdata_out[31:16] == 16'h0000)
		else $error("upper half not zero");
	AST_MID_ZERO: assert property (cfg_ack_out |-> cfg_rdata_out[14:11] == 4'h0)
		else $error("bits 14-11 not zero");
	AST_LOW_ZERO: assert property (cfg_ack_out |-> cfg_rdata_out[7:5] == 3'h0)
		else $error("bits 7-5 not zero");
	AST_PM_COPY: assert property (s_wr_hi |=> pm_cap_wake_cold_out == $past(cfg_req_in.wdata[15]))
		else $error("power capability copy wrong");
	AST_WAKE: assert property (cur_reg.f.wake_ign && irq_pending_in |=> wake_event_out)
		else $error("wake not raised");
	AST_WAKE_GATED: assert property (!cur_reg.f.wake_ign && !master_interrupt_gate_in |=> !wake_event_out)
		else $error("wake not gated");
	AST_VENDOR26: assert property (s_wr_hi |=> link_vendor_bit26_out == $past(cfg_req_in.wdata[10]))
		else $error("vendor bit 26 wrong");
	AST_SHORT_READ: assert property (rd_req_in && !long_rd |=> rd_cmd_valid_out && rd_cmd_out == `CMD_MEM_READ)
		else $error("short read command wrong");
	AST_MULT_READ: assert property (rd_req_in && long_rd && cur_reg.f.rd_sel == `RDSEL_MULTIPLE
		|=> rd_cmd_out == `CMD_MEM_READ_MUL)
		else $error("multiple read command wrong");
	AST_LINE_READ: assert property (rd_req_in && long_rd && cur_reg.f.rd_sel[0] == cur_reg.f.rd_sel[1]
		|=> rd_cmd_out == `CMD_MEM_READ_LN)
		else $error("line read command wrong");
	AST_EE_LOAD: assert property (ee_word_in.valid && ee_word_in.addr == `EE_RDSEL_WORD
		|=> cur_reg.f.rd_sel == $past(ee_word_in.data[1:0]))
		else $error("EEPROM load of field wrong");
	AST_ABORT: assert property (link_req_in.valid && !link_req_in.sclk_active && !cur_reg.f.sup_abort
		|=> link_abort_out && !link_done_out)
		else $error("idle link access not aborted");
	AST_FILL: assert property (link_req_in.valid && !link_req_in.sclk_active && cur_reg.f.sup_abort
		|=> link_done_out && !link_abort_out && link_rdata_out == `LINK_FILL_DATA)
		else $error("idle link access not filled");
	AST_ROUTE: assert property (cur_reg.f.pin_route |-> !general_pin_three_oe_out && !general_pin_two_oe_out
		&& ee_clk_out == gpio_three_drive_in)
		else $error("pins not routed");
	AST_SCLK_BYP: assert property (cur_reg.f.sclk_byp |-> sclk_run_out)
		else $error("serial clock gated");
	AST_HCLK_BYP: assert property (cur_reg.f.hclk_byp |-> hclk_run_out)
		else $error("host clock gated");
	AST_KEEP: assert property (s_wr_hi ##0 cfg_req_in.be[0] && cfg_req_in.wdata[0] |=> clkrun_keep_out)
		else $error("host clock not kept");
	AST_RESET_SEL: assert property (disable iff (1'h0) reset_in |=> cur_reg.f.rd_sel == `RDSEL_LINE)
		else $error("field not reset");
	AST_RMW: assert property (s_write_all ##1 (!cfg_req_in.sel && !ee_word_in.valid) ##1 s_read
		|=> cfg_rdata_out == `MCFG_WRITE_MASK)
		else $error("reserved bits took a write");

endmodule
`default_nettype wire

// ==== pkg/misc_cfg_defines.svh ====
`ifndef MISC_CFG_DEFINES_SVH
`define MISC_CFG_DEFINES_SVH
// Functional notes
// - Bits 31-16 always read zero
// - Bit 15 drives power capability bit 15
// - Bits 14-11 always read zero
// - Bit 10 lets wake ignore master gate
// - Link vendor bit 26 mirrors bit 10
// - One or two phase reads use Memory Read
// - Longer reads: field picks read command
// - EEPROM word 12 bits 1-0 load field
// - Bits 7-5 always read zero
// - Bit 4 clear: idle link access aborts
// - Bit 4 set: idle link access returns FFFFFFFFh
// - Bit 3 routes pins to EEPROM bus
// - Bit 2 bypasses serial clock gate
// - Bit 1 bypasses host clock gate
// - Bit 0 keeps host clock running
// - Read command field resets to 00

// ==========================================
// Register placement and reset
`define MCFG_OFFSET      8'hF0
`define MCFG_RESET       32'h0000_0000
`define MCFG_WRITE_MASK  32'h0000_871F

// ==========================================
// Field positions
`define BIT_WAKE_COLD    15
`define BIT_WAKE_IGN     10
`define BIT_RDSEL_HI     9
`define BIT_RDSEL_LO     8
`define BIT_SUP_ABORT    4
`define BIT_PIN_ROUTE    3
`define BIT_SCLK_BYP     2
`define BIT_HCLK_BYP     1
`define BIT_KEEP_HCLK    0

// ==========================================
// Read command selection and bus commands
`define RDSEL_LINE       2'h0
`define RDSEL_PLAIN      2'h1
`define RDSEL_MULTIPLE   2'h2
`define CMD_MEM_READ     4'h6
`define CMD_MEM_READ_LN  4'hE
`define CMD_MEM_READ_MUL 4'hC
`define SHORT_READ_MAX   8'h02

// ==========================================
// EEPROM load and link fill
`define EE_RDSEL_WORD    8'h0C
`define LINK_FILL_DATA   32'hFFFF_FFFF

`endif

// ==== pkg/misc_cfg_pkg.sv ====
`default_nettype none
package misc_cfg_pkg;

	// ==========================================
	// Configuration access request
	typedef struct packed {
		logic        sel;
		logic        wr;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} cfg_req_s;

	// EEPROM initial load word
	typedef struct packed {
		logic        valid;
		logic [7:0]  addr;
		logic [15:0] data;
	} ee_word_s;

	// Link register access
	typedef struct packed {
		logic        valid;
		logic        sclk_active;
		logic [31:0] rdata;
	} link_req_s;

	// Writable fields
	typedef struct packed {
		logic       wake_cold;
		logic       wake_ign;
		logic [1:0] rd_sel;
		logic       sup_abort;
		logic       pin_route;
		logic       sclk_byp;
		logic       hclk_byp;
		logic       keep_hclk;
	} fields_s;

	// Whole block state
	typedef struct packed {
		fields_s     f;
		logic        ack;
		logic [31:0] rdata;
		logic        wake;
		logic        rd_vld;
		logic [3:0]  rd_cmd;
		logic        lk_done;
		logic        lk_abort;
		logic [31:0] lk_rdata;
	} state_s;

endpackage
`default_nettype wire

// ==== verif/link_side_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module link_side_model
(
	// Bench control
	input  wire logic                    clk_in,
	input  wire logic                    go_in,
	input  wire logic                    active_in,
	input  wire logic [31:0]             data_in,
	// Request toward the block
	output misc_cfg_pkg::link_req_s      req_out
);
	import misc_cfg_pkg::*;
	logic [31:0] idle_reg = 32'h0000_0000;
	// Idle data lines toggle so stale data never looks valid
	always_ff @(posedge clk_in)
		idle_reg <= ~idle_reg;
	// Request fields
	assign req_out.valid       = go_in;
	assign req_out.sclk_active = active_in;
	assign req_out.rdata       = go_in ? data_in : idle_reg;
endmodule
`default_nettype wire

// ==== verif/misc_host_config_register_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module misc_host_config_register_bench;
	import misc_cfg_pkg::*;
	logic ref_clk_in, reset_in, irq, gate, rd_req, lk_go, lk_act;
	logic ack, wake, cap15, vb26, cvld, ldone, labt, srun, hrun, keep;
	logic p3o, p3e, p2o, p2e, eco, ece, edo, ede, g3s, g2s;
	logic [7:0]  phases;
	logic [3:0]  cmd;
	logic [31:0] lk_data, lfsr, rd, rdata, lrdata;
	logic [15:0] rnd;
	cfg_req_s    cfg_req;
	ee_word_s    ee_word;
	link_req_s   link_req;
	int          n_mismatch, n_tests;
	// Pin levels: driven by the block or external, EEPROM bus pulled up
	wire logic p3_pin = p3e ? p3o : rnd[0];
	wire logic p2_pin = p2e ? p2o : rnd[1];
	wire logic ec_pin = ece ? eco : 1'b1;
	wire logic ed_pin = ede ? edo : 1'b1;

	// ====================
	// Clock, design and partner
	initial
	begin
		ref_clk_in = 1'b0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end
	misc_host_config_register u_misc_host_config_register (
		.ref_clk_in(ref_clk_in), .reset_in(reset_in), .cfg_req_in(cfg_req),
		.cfg_ack_out(ack), .cfg_rdata_out(rdata), .ee_word_in(ee_word),
		.irq_pending_in(irq), .master_interrupt_gate_in(gate), .wake_event_out(wake),
		.pm_cap_wake_cold_out(cap15), .link_vendor_bit26_out(vb26), .rd_req_in(rd_req),
		.rd_phases_in(phases), .rd_cmd_valid_out(cvld), .rd_cmd_out(cmd),
		.link_req_in(link_req), .link_done_out(ldone), .link_abort_out(labt),
		.link_rdata_out(lrdata), .general_pin_three_in(p3_pin), .general_pin_two_in(p2_pin),
		.gpio_three_drive_in(rnd[2]), .gpio_three_oe_in(rnd[3]), .gpio_two_drive_in(rnd[4]),
		.gpio_two_oe_in(rnd[5]), .general_pin_three_out(p3o), .general_pin_three_oe_out(p3e),
		.general_pin_two_out(p2o), .general_pin_two_oe_out(p2e), .gpio_three_seen_out(g3s),
		.gpio_two_seen_out(g2s), .ee_clk_drive_in(rnd[6]), .ee_clk_oe_in(rnd[7]),
		.ee_data_drive_in(rnd[8]), .ee_data_oe_in(rnd[9]), .ee_clk_pin_in(ec_pin),
		.ee_data_pin_in(ed_pin), .ee_clk_out(eco), .ee_clk_oe_out(ece), .ee_data_out(edo),
		.ee_data_oe_out(ede), .sclk_gate_en_in(rnd[10]), .hclk_gate_en_in(rnd[11]),
		.hclk_needed_in(rnd[12]), .sclk_run_out(srun), .hclk_run_out(hrun),
		.clkrun_keep_out(keep));
	link_side_model u_link_side_model (.clk_in(ref_clk_in), .go_in(lk_go),
		.active_in(lk_act), .data_in(lk_data), .req_out(link_req));

	// ====================
	// Random source
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [3:0] exp_cmd(input logic [7:0] ph, input logic [1:0] sel);
		if (ph <= 8'h02)
			return 4'h6;
		return (sel == 2'h1) ? 4'h6 : (sel == 2'h2) ? 4'hC : 4'hE;
	endfunction
	always @(posedge ref_clk_in)
	begin
		lfsr <= step(lfsr);
		rnd  <= lfsr[15:0];
	end

	// ====================
	// Tasks
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task cfg(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		cfg_req <= '{1'b1, wr, a, 4'hF, d};
		@(posedge ref_clk_in);
		cfg_req.sel <= 1'b0;
		#1 rd = rdata;
		chk("cfg ack", ack, a[7:2] == 6'h3C);
	endtask
	task rdcmd(input logic [7:0] ph, input logic [1:0] sel);
		@(posedge ref_clk_in);
		rd_req <= 1'b1;
		phases <= ph;
		@(posedge ref_clk_in);
		rd_req <= 1'b0;
		#1 chk("cmd valid", cvld, 1);
		chk("cmd", cmd, exp_cmd(ph, sel));
	endtask
	task link(input logic act, input logic [31:0] d, input logic ab, input logic [31:0] er);
		@(posedge ref_clk_in);
		{lk_go, lk_act, lk_data} <= {1'b1, act, d};
		@(posedge ref_clk_in);
		lk_go <= 1'b0;
		#1 chk("abort", labt, ab);
		chk("done", ldone, !ab);
		chk("link data", lrdata, er);
	endtask
	task ee(input logic [7:0] a, input logic [15:0] d, input logic [1:0] exp);
		@(posedge ref_clk_in);
		ee_word <= '{1'b1, a, d};
		@(posedge ref_clk_in);
		ee_word.valid <= 1'b0;
		cfg(1'b0, 8'hF0, 32'h0);
		chk("eeprom field", rd[9:8], exp);
	endtask
	task wrap_up;
		$display("Checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ====================
	// Watchdog
	initial
	begin
		#(40 * 3000);
		n_mismatch++;
		wrap_up;
	end

	// ====================
	// Main sequence
	initial
	begin
		{irq, gate, rd_req, lk_go, lk_act, phases, lk_data} = '0;
		cfg_req = '0;
		ee_word = '0;
		rnd = '0;
		lfsr = 32'h0000_0041;
		n_mismatch = 0;
		n_tests = 0;
		reset_in = 1'b1;
		repeat (20) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		cfg(1'b0, 8'hF0, 32'h0);
		chk("reset value", rd, 32'h0);
		cfg(1'b1, 8'hF0, 32'hFFFF_FFFF);
		cfg(1'b1, 8'hE0, 32'h0);
		cfg(1'b0, 8'hF0, 32'h0);
		chk("readback", rd, 32'h0000_871F);
		chk("cold bit", cap15, 1);
		chk("vendor bit", vb26, 1);
		chk("sclk run", srun, 1);
		chk("hclk run", hrun, 1);
		chk("keep", keep, 1);
		chk("pin oe", {p3e, p2e}, 0);
		chk("ee clk", {ece, eco}, {rnd[3], rnd[2]});
		chk("ee data", {ede, edo}, {rnd[5], rnd[4]});
		chk("gpio seen", {g3s, g2s}, {ec_pin, ed_pin});
		irq <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		#1 chk("wake ignore", wake, 1);
		cfg(1'b1, 8'hF0, 32'h0);
		chk("pin drive", {p3e, p3o, p2e, p2o}, {rnd[3], rnd[2], rnd[5], rnd[4]});
		chk("ee own", {ece, eco, ede, edo}, {rnd[7], rnd[6], rnd[9], rnd[8]});
		chk("gpio direct", {g3s, g2s}, {p3_pin, p2_pin});
		repeat (3) @(posedge ref_clk_in);
		#1 chk("wake gated", wake, 0);
		chk("vendor clear", vb26, 0);
		chk("cold clear", cap15, 0);
		gate <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		#1 chk("wake open", wake, 1);
		link(1'b0, lfsr, 1'b1, 32'h0);
		link(1'b1, lfsr, 1'b0, lfsr);
		cfg(1'b1, 8'hF0, 32'h10);
		link(1'b0, lfsr, 1'b0, 32'hFFFF_FFFF);
		for (int s = 0; s < 4; s++)
		begin
			cfg(1'b1, 8'hF0, {22'h0, s[1:0], 8'h00});
			rdcmd(8'h01 + lfsr[0], s[1:0]);
			rdcmd(8'h03, s[1:0]);
			rdcmd({1'b1, lfsr[6:0]}, s[1:0]);
		end
		ee(8'h0C, lfsr[15:0], lfsr[1:0]);
		ee(8'h0D, ~rd[15:0], rd[9:8]);
		wrap_up;
	end
endmodule
`default_nettype wire
